// File: design/ckfm_map.svh
`ifndef CKFM_MAP_SVH
`define CKFM_MAP_SVH
// Notes on behaviour
// - Readback bit 3 reads 1 while VCO frequency is above threshold, read only.
// - Readback bit 2 reads 1 while secondary reference exceeds selected threshold.
// - Readback bit 1 reads 1 while primary reference exceeds the same threshold.
// - Readback bit 0 shows digital lock detect, 1 while the PLL is locked.
// - Control bit 7 picks driver type: 0 LVPECL (default), 1 CMOS.
// - In CMOS, bits 6:5 enable outputs: 00 none, 01 A, 10 B, 11 both.
// - Bits 4:3 set polarity; LVPECL ignores bit 4, bit 3 low gives A normal.

// Register offsets
`define CKFM_OFS_THRESH 10'h01A
`define CKFM_OFS_READBACK 10'h01F
`define CKFM_OFS_CTRL_ZERO 10'h0F0

// Field positions
`define CKFM_BIT_THRESH_SEL 6
`define CKFM_BIT_VCO_ABOVE 3
`define CKFM_BIT_SEC_ABOVE 2
`define CKFM_BIT_PRI_ABOVE 1
`define CKFM_BIT_LOCKED 0
`define CKFM_BIT_FORMAT 7
`define CKFM_BIT_EN_B 6
`define CKFM_BIT_EN_A 5
`define CKFM_BIT_POL_HI 4
`define CKFM_BIT_POL_LO 3

// Reset values
`define CKFM_RST_CTRL_ZERO 8'h64
`define CKFM_RST_THRESH 8'h00
`endif

// File: design/ckfm_pkg.sv
package ckfm_pkg;
    typedef logic [9:0] ckfm_addr_t;
    typedef logic [7:0] ckfm_byte_t;
    // Driver type chosen by the format bit
    typedef enum logic {CKFM_LVPECL, CKFM_CMOS} ckfm_fmt_e;
endpackage

// File: design/ckfm_out_fmt.sv
`timescale 1ns/1ns
`include "ckfm_map.svh"
// Decodes the output-channel-zero control byte into driver controls
module ckfm_out_fmt (
    input wire ckfm_pkg::ckfm_byte_t i_ctrl, // Control byte
    output ckfm_pkg::ckfm_fmt_e o_fmt, // Driver type
    output logic o_en_a, // CMOS output A driving
    output logic o_en_b, // CMOS output B driving
    output logic o_inv_a, // Output A inverted
    output logic o_inv_b // Output B inverted
);
    import ckfm_pkg::*;

    // Format select, enables and polarity decode
    always_comb begin
        o_fmt = i_ctrl[`CKFM_BIT_FORMAT] ? CKFM_CMOS : CKFM_LVPECL;
        // Enables only matter in CMOS; LVPECL leaves the single-ended pair tristated
        o_en_a = i_ctrl[`CKFM_BIT_FORMAT] & i_ctrl[`CKFM_BIT_EN_A];
        o_en_b = i_ctrl[`CKFM_BIT_FORMAT] & i_ctrl[`CKFM_BIT_EN_B];
        if (i_ctrl[`CKFM_BIT_FORMAT]) begin
            // CMOS: bit 3 inverts A; B inverts when bits 4 and 3 differ
            o_inv_a = i_ctrl[`CKFM_BIT_POL_LO];
            o_inv_b = i_ctrl[`CKFM_BIT_POL_HI] ^ i_ctrl[`CKFM_BIT_POL_LO];
        end else begin
            // LVPECL: complementary pair, bit 4 ignored
            o_inv_a = i_ctrl[`CKFM_BIT_POL_LO];
            o_inv_b = ~i_ctrl[`CKFM_BIT_POL_LO];
        end
    end
endmodule

// File: design/ckfm_regs.sv
`timescale 1ns/1ns
`include "ckfm_map.svh"
// Readback flags and output-channel-zero control register
module ckfm_regs (
    input wire logic i_ref_clk, // 100 MHz clock
    input wire logic i_sys_rst, // Async reset, active high
    input wire ckfm_pkg::ckfm_addr_t i_reg_addr, // Register address
    input wire logic i_reg_wr, // Write strobe, one cycle
    input wire logic i_reg_rd, // Read strobe, one cycle
    input wire ckfm_pkg::ckfm_byte_t i_reg_wdata, // Write data
    output ckfm_pkg::ckfm_byte_t o_reg_rdata, // Read data
    output logic o_reg_rvalid, // Read data valid pulse
    input wire logic i_vco_above, // VCO monitor above threshold
    input wire logic i_pri_ref_above, // Primary reference monitor
    input wire logic i_sec_ref_above, // Secondary reference monitor
    input wire logic i_pll_locked, // Digital lock detector
    output logic o_ref_thresh_sel, // Threshold select to monitors
    output ckfm_pkg::ckfm_fmt_e o_fmt, // Channel zero driver type
    output logic o_lvpecl_en, // Differential driver enabled
    output logic o_channel_output_a_oe, // CMOS output A enable
    output logic o_channel_output_b_oe, // CMOS output B enable
    output logic o_inv_a, // Output A inverted
    output logic o_inv_b, // Output B inverted
    output logic [1:0] o_drive_level, // Differential swing code
    output logic o_power_down // Differential driver power-down
);
    import ckfm_pkg::*;

    ckfm_byte_t output_zero_control;
    ckfm_byte_t threshold_control;
    logic [3:0] pll_monitor_readback;
    ckfm_fmt_e next_fmt;
    logic next_en_a;
    logic next_en_b;
    logic next_inv_a;
    logic next_inv_b;

    // Address match helper, used by writes and reads alike
    function automatic logic hit(input ckfm_addr_t a, input ckfm_addr_t ofs);
        hit = (a == ofs);
    endfunction

    // Output control register; lower bits kept for the drive and power stages
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            output_zero_control <= `CKFM_RST_CTRL_ZERO;
        end else if (i_reg_wr && hit(i_reg_addr, `CKFM_OFS_CTRL_ZERO)) begin
            output_zero_control <= i_reg_wdata;
        end
    end

    // Threshold select shared by both reference monitors
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            threshold_control <= `CKFM_RST_THRESH;
        end else if (i_reg_wr && hit(i_reg_addr, `CKFM_OFS_THRESH)) begin
            threshold_control <= i_reg_wdata & 8'h40;
        end
    end

    // Status flags follow monitors; a write to this address has no path here
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pll_monitor_readback <= 4'h0;
        end else begin
            pll_monitor_readback[`CKFM_BIT_VCO_ABOVE] <= i_vco_above;
            pll_monitor_readback[`CKFM_BIT_SEC_ABOVE] <= i_sec_ref_above;
            pll_monitor_readback[`CKFM_BIT_PRI_ABOVE] <= i_pri_ref_above;
            pll_monitor_readback[`CKFM_BIT_LOCKED] <= i_pll_locked;
        end
    end

    // Read port: one cycle latency, unmapped addresses read zero
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (!i_reg_rd) begin
                o_reg_rdata <= 8'h00;
            end else if (hit(i_reg_addr, `CKFM_OFS_CTRL_ZERO)) begin
                o_reg_rdata <= output_zero_control;
            end else if (hit(i_reg_addr, `CKFM_OFS_THRESH)) begin
                o_reg_rdata <= threshold_control;
            end else if (hit(i_reg_addr, `CKFM_OFS_READBACK)) begin
                o_reg_rdata <= {4'h0, pll_monitor_readback};
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end

    ckfm_out_fmt u_fmt (
        .i_ctrl(output_zero_control),
        .o_fmt(next_fmt),
        .o_en_a(next_en_a),
        .o_en_b(next_en_b),
        .o_inv_a(next_inv_a),
        .o_inv_b(next_inv_b)
    );

    // Driver controls registered so pins never see decode glitches
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_fmt <= CKFM_LVPECL;
            o_lvpecl_en <= 1'b1;
            o_channel_output_a_oe <= 1'b0;
            o_channel_output_b_oe <= 1'b0;
            o_inv_a <= 1'b0;
            o_inv_b <= 1'b1;
            o_drive_level <= 2'h2;
            o_power_down <= 1'b0;
            o_ref_thresh_sel <= 1'b0;
        end else begin
            o_fmt <= next_fmt;
            o_lvpecl_en <= (next_fmt == CKFM_LVPECL);
            o_channel_output_a_oe <= next_en_a;
            o_channel_output_b_oe <= next_en_b;
            o_inv_a <= next_inv_a;
            o_inv_b <= next_inv_b;
            o_drive_level <= output_zero_control[2:1];
            o_power_down <= output_zero_control[0];
            o_ref_thresh_sel <= threshold_control[`CKFM_BIT_THRESH_SEL];
        end
    end

    // Checks
    // Readback data in the cycle after the read shows the monitor two edges back
    property p_vco_flag;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) && i_reg_rd && hit(i_reg_addr, `CKFM_OFS_READBACK)
        |=> o_reg_rvalid && o_reg_rdata[`CKFM_BIT_VCO_ABOVE] == $past(i_vco_above, 2);
    endproperty
    a_vco_flag: assert property (p_vco_flag) else $error("VCO flag lost");

    // Checked against the pin, not the flag register, so a lost stage shows
    property p_sec_flag;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) && i_reg_rd && hit(i_reg_addr, `CKFM_OFS_READBACK)
        |=> o_reg_rvalid && o_reg_rdata[`CKFM_BIT_SEC_ABOVE] == $past(i_sec_ref_above, 2);
    endproperty
    a_sec_flag: assert property (p_sec_flag) else $error("Secondary flag wrong");

    // Skips the edge right after reset, where the flags still hold zero
    property p_pri_flag;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) |-> pll_monitor_readback[`CKFM_BIT_PRI_ABOVE] == $past(i_pri_ref_above);
    endproperty
    a_pri_flag: assert property (p_pri_flag) else $error("Primary flag wrong");

    // Lock held over two edges out of reset must show in the flag
    property p_lock_flag;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!i_sys_rst && i_pll_locked) ##1 i_pll_locked |-> pll_monitor_readback[`CKFM_BIT_LOCKED];
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("Lock flag wrong");

    // Driver type follows the written format bit two edges later
    property p_format;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_reg_wr && hit(i_reg_addr, `CKFM_OFS_CTRL_ZERO)
        |=> ##1 (o_fmt == ckfm_fmt_e'($past(i_reg_wdata[7], 2))) && (o_lvpecl_en != o_fmt);
    endproperty
    a_format: assert property (p_format) else $error("Format not applied");

    // Single-ended enables only open in CMOS
    property p_enables;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_reg_wr && hit(i_reg_addr, `CKFM_OFS_CTRL_ZERO)
        |=> ##1 o_channel_output_a_oe == ($past(i_reg_wdata[7], 2) & $past(i_reg_wdata[5], 2))
        && o_channel_output_b_oe == ($past(i_reg_wdata[7], 2) & $past(i_reg_wdata[6], 2));
    endproperty
    a_enables: assert property (p_enables) else $error("CMOS enables wrong");

    property p_polarity;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_fmt == CKFM_LVPECL) |-> (o_inv_a != o_inv_b);
    endproperty
    a_polarity: assert property (p_polarity) else $error("Pair not complementary");

    property p_status_ro;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_reg_wr && hit(i_reg_addr, `CKFM_OFS_READBACK)
        |=> $stable(output_zero_control) && $stable(threshold_control)
        && pll_monitor_readback == {$past(i_vco_above), $past(i_sec_ref_above),
                                    $past(i_pri_ref_above), $past(i_pll_locked)};
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("Readback took a write");

    // Out of reset, channel zero sits in LVPECL with the default driver settings
    property p_reset_ctrl;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $past(i_sys_rst) |-> output_zero_control == `CKFM_RST_CTRL_ZERO
        && o_fmt == CKFM_LVPECL && o_drive_level == 2'h2
        && !o_channel_output_a_oe && !o_channel_output_b_oe && !o_inv_a && o_inv_b;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("Reset defaults wrong");

    // Threshold select reaches both reference monitors two edges after the write
    property p_thresh_sel;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_reg_wr && hit(i_reg_addr, `CKFM_OFS_THRESH)
        |=> ##1 o_ref_thresh_sel == $past(i_reg_wdata[`CKFM_BIT_THRESH_SEL], 2);
    endproperty
    a_thresh_sel: assert property (p_thresh_sel) else $error("Threshold select lost");

    // CMOS polarity: bit 3 inverts A, bits 4 and 3 together decide B
    property p_cmos_pol;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_reg_wr && hit(i_reg_addr, `CKFM_OFS_CTRL_ZERO) && i_reg_wdata[`CKFM_BIT_FORMAT]
        |=> ##1 o_inv_a == $past(i_reg_wdata[`CKFM_BIT_POL_LO], 2)
        && o_inv_b == ($past(i_reg_wdata[`CKFM_BIT_POL_HI], 2)
        ^ $past(i_reg_wdata[`CKFM_BIT_POL_LO], 2));
    endproperty
    a_cmos_pol: assert property (p_cmos_pol) else $error("CMOS polarity wrong");

    // LVPECL polarity: bit 3 alone decides, bit 4 has no effect
    property p_pecl_pol;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_reg_wr && hit(i_reg_addr, `CKFM_OFS_CTRL_ZERO) && !i_reg_wdata[`CKFM_BIT_FORMAT]
        |=> ##1 o_inv_a == $past(i_reg_wdata[`CKFM_BIT_POL_LO], 2)
        && o_inv_b == !$past(i_reg_wdata[`CKFM_BIT_POL_LO], 2);
    endproperty
    a_pecl_pol: assert property (p_pecl_pol) else $error("LVPECL polarity wrong");

    // LVPECL keeps both single-ended drivers off and the differential one on
    property p_pecl_tri;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        o_fmt == CKFM_LVPECL |-> o_lvpecl_en && !o_channel_output_a_oe && !o_channel_output_b_oe;
    endproperty
    a_pecl_tri: assert property (p_pecl_tri) else $error("CMOS enable in LVPECL");

    // Read data is zero outside the cycle after a read, so stale flags never leak
    property p_rd_idle;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("Read data outside a read");
endmodule

// File: verification/ckfm_regs_tb_top.sv
`timescale 1ns/1ns
`include "ckfm_map.svh"
module ckfm_regs_tb_top;
    import ckfm_pkg::*;
    logic clk, rst, wr, rd, vco, pri, sec, lck, rvalid, tsel;
    logic lv_en, oe_a, oe_b, inv_a, inv_b, pd;
    logic [1:0] drv;
    ckfm_fmt_e fmt;
    ckfm_addr_t addr;
    ckfm_byte_t wdata, rdata, ctrl, v;
    int failures, checked;
    integer seed;

    ckfm_regs uut (.i_ref_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_vco_above(vco), .i_pri_ref_above(pri), .i_sec_ref_above(sec), .i_pll_locked(lck),
        .o_ref_thresh_sel(tsel), .o_fmt(fmt), .o_lvpecl_en(lv_en),
        .o_channel_output_a_oe(oe_a), .o_channel_output_b_oe(oe_b), .o_inv_a(inv_a),
        .o_inv_b(inv_b), .o_drive_level(drv), .o_power_down(pd));

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Order: format, diff enable, oe a, oe b, inv a, inv b, swing, power-down
    function automatic logic [8:0] exp_drv(input ckfm_byte_t c);
        logic cm;
        cm = c[7];
        return {cm, ~cm, cm & c[5], cm & c[6], c[3], cm ? c[4] ^ c[3] : ~c[3], c[2:1], c[0]};
    endfunction

    task automatic check_byte(input string nm, input ckfm_byte_t e, input ckfm_byte_t g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_drv(input string nm, input logic [8:0] e);
        logic [8:0] g;
        g = {fmt, lv_en, oe_a, oe_b, inv_a, inv_b, drv, pd};
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Strobes are one-cycle pulses, so each access lowers its strobe at the taking edge
    task automatic write_reg(input ckfm_addr_t a, input ckfm_byte_t d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic read_check(input string nm, input ckfm_addr_t a, input ckfm_byte_t e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check_byte({nm, " valid"}, 8'h01, {7'h00, rvalid});
        check_byte(nm, e, rdata);
        @(posedge clk);
        #1;
        check_byte("idle rdata", 8'h00, rdata);
    endtask

    task automatic summarize();
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence: reset, control decode sweep, flags, threshold, refusals, mid-run reset
    initial begin
        {rst, wr, rd, vco, pri, sec, lck} = 7'b1000000;
        addr = '0;
        wdata = '0;
        failures = 0;
        checked = 0;
        seed = 32'h8d2fca6f;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check_drv("reset drivers", exp_drv(`CKFM_RST_CTRL_ZERO));
        read_check("ctrl reset", `CKFM_OFS_CTRL_ZERO, `CKFM_RST_CTRL_ZERO);
        read_check("thresh reset", `CKFM_OFS_THRESH, `CKFM_RST_THRESH);
        // First 16 sweep every CMOS enable and polarity code, next 4 LVPECL polarity
        for (int i = 0; i < 48; i++) begin
            ctrl = 8'($random(seed));
            if (i < 16) ctrl[7:3] = {1'b1, 4'(i)};
            else if (i < 20) ctrl = {1'b0, ctrl[6:5], 2'(i), ctrl[2:0]};
            write_reg(`CKFM_OFS_CTRL_ZERO, ctrl);
            repeat (2) @(posedge clk);
            #1 check_drv("drivers", exp_drv(ctrl));
            read_check("ctrl", `CKFM_OFS_CTRL_ZERO, ctrl);
        end
        // A write to the readback place must not disturb the flags or the control byte
        for (int i = 0; i < 24; i++) begin
            v = 8'($random(seed));
            if (i < 16) v[3:0] = 4'(i);
            @(posedge clk);
            {vco, sec, pri, lck} <= v[3:0];
            repeat (2) @(posedge clk);
            write_reg(`CKFM_OFS_READBACK, ~v);
            read_check("flags", `CKFM_OFS_READBACK, {4'h0, v[3:0]});
            read_check("ctrl after flag write", `CKFM_OFS_CTRL_ZERO, ctrl);
        end
        // Threshold register keeps only its select bit
        for (int k = 0; k < 2; k++) begin
            v = (k != 0) ? 8'hBF : 8'hFF;
            write_reg(`CKFM_OFS_THRESH, v);
            repeat (2) @(posedge clk);
            #1 check_byte("thresh sel", {7'h00, v[6]}, {7'h00, tsel});
            read_check("thresh", `CKFM_OFS_THRESH, v & 8'h40);
        end
        write_reg(10'h3FF, ~ctrl);
        read_check("unmapped", 10'h3FF, 8'h00);
        read_check("ctrl kept", `CKFM_OFS_CTRL_ZERO, ctrl);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1 check_drv("drivers in reset", exp_drv(`CKFM_RST_CTRL_ZERO));
        @(posedge clk);
        rst <= 1'b0;
        read_check("ctrl after reset", `CKFM_OFS_CTRL_ZERO, `CKFM_RST_CTRL_ZERO);
        summarize();
    end
endmodule
